//--- srf_ramp_filter.sv
// What this block does
// - In a ramping mode a new setpoint write starts a ramp unless it lands in the cycle a ramp ends.
// - When the working setpoint reaches the target the ramp ends and regulation continues there.
// - The ramp rate is in input units per minute.
// - Ramp-then-PID follows with PID gains, ramp-then-table with table gains.
// - Each loop keeps its own rate and ramp state.
// - Changing into a ramping mode keeps control running with no step in the setpoint.
// - After a ramp, writing a different setpoint starts a fresh ramp.
// - A ramp-active flag per loop is output and readable.
// - During a ramp the setpoint fed to the PID loop moves toward the target.
// - Switching control on starts regulation at the present setpoint without ramping.
// - The enabled filter subtracts the periodic signature before the PID loop.
// - The filter synchronises to a 60 or 50 Hz mains setting.
// - Tap counts 1 to 25 are accepted and 1 bypasses the filter.
// - The tap count resets to 7.
`timescale 1ns/1ps
`include "srf_defines.svh"
module srf_ramp_filter #(
  parameter int unsigned MAINS_HI_CYCLES = `SRF_CLK_HZ / `SRF_MAINS_HI_HZ,
  parameter int unsigned MAINS_LO_CYCLES = `SRF_CLK_HZ / `SRF_MAINS_LO_HZ,
  parameter int unsigned UPDATE_CYCLES   = `SRF_CLK_HZ / 1000 * `SRF_UPDATE_MS
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  input  wire logic [7:0]             awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [7:0]             araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic [1:0][15:0]       sample_in,
  input  wire logic [1:0]             sample_in_valid,
  output logic      [1:0][15:0]       sample_out,
  output logic      [1:0]             sample_out_valid,
  output logic      [1:0][15:0]       pid_setpoint,
  output logic      [1:0]             ramp_active_flag,
  output logic      [1:0]             gain_table_select,
  output logic                        irq
);
  srf_pkg::srf_mode_e       mode [2], next_mode [2];
  srf_pkg::srf_state_e      st [2], next_st [2];
  logic [1:0]               on, next_on, tsel, next_tsel;
  logic [15:0]              target [2], next_target [2], rate [2], next_rate [2];
  logic [15:0]              wsp [2], next_wsp [2], base [2], next_base [2];
  logic signed [15:0]       est [2][25], next_est [2][25];
  logic [4:0]               taps [2], next_taps [2], bin [2], next_bin [2];
  logic [1:0][15:0]         next_sout;
  logic [1:0]               next_soutv;
  logic                     mains_sel, next_mains_sel, next_irq;
  logic [3:0]               istat, next_istat, imask, next_imask;
  logic [23:0]              upd_cnt, next_upd_cnt, mains_cnt, next_mains_cnt;
  logic                     next_awready, next_arready, next_bvalid, next_rvalid;
  logic [1:0]               next_bresp, next_rresp;
  logic [31:0]              next_rdata;
  logic                     wr_fire, rd_fire, upd_tick, mains_tick;
  logic [23:0]              mains_last;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:6] == 2'h0 && a[1:0] == 2'h0 && a[4:0] <= `SRF_OFF_TAPS)
          || a == `SRF_ADDR_SYS || a == `SRF_ADDR_IRQ_STAT || a == `SRF_ADDR_IRQ_MASK;
  endfunction

  function automatic logic is_ramp(input srf_pkg::srf_mode_e m);
    is_ramp = (m == srf_pkg::ramp_then_pid_mode) || (m == srf_pkg::ramp_then_table_mode);
  endfunction

  assign wr_fire    = awready && awvalid && wvalid;
  assign rd_fire    = arready && arvalid;
  assign upd_tick   = (upd_cnt == 24'(UPDATE_CYCLES - 1));
  assign mains_last = mains_sel ? 24'(MAINS_LO_CYCLES - 1) : 24'(MAINS_HI_CYCLES - 1);
  assign mains_tick = (mains_cnt == mains_last);
  assign ramp_active_flag[0] = st[0][2];
  assign ramp_active_flag[1] = st[1][2];
  assign gain_table_select   = tsel;

  always_comb
  begin
    logic              l;
    logic [4:0]        o;
    logic [15:0]       step, d;
    logic signed [16:0] diff;
    logic signed [17:0] resid;
    logic signed [15:0] e;
    l = awaddr[5];
    o = awaddr[4:0];
    step = 16'h0000;
    d = 16'h0000;
    diff = 17'sh0_0000;
    resid = 18'sh0_0000;
    e = 16'sh0000;
    next_mode = mode;
    next_st = st;
    next_on = on;
    next_tsel = tsel;
    next_target = target;
    next_rate = rate;
    next_wsp = wsp;
    next_base = base;
    next_est = est;
    next_taps = taps;
    next_bin = bin;
    next_sout = sample_out;
    next_soutv = 2'h0;
    next_mains_sel = mains_sel;
    next_istat = istat;
    next_imask = imask;
    next_upd_cnt = upd_tick ? 24'h00_0000 : upd_cnt + 24'h00_0001;
    next_mains_cnt = mains_tick ? 24'h00_0000 : mains_cnt + 24'h00_0001;
    next_awready = awvalid && wvalid && !awready && !bvalid;
    next_arready = arvalid && !arready && !rvalid;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !rready;
    next_rresp = rresp;
    next_rdata = rdata;
    if (mains_cnt > mains_last)
    begin
      next_mains_cnt = 24'h00_0000;
    end
    if (wr_fire)
    begin
      next_bvalid = 1'b1;
      next_bresp = mapped(awaddr) ? `SRF_RESP_OKAY : `SRF_RESP_SLVERR;
      if (wstrb != 4'h0)
      begin
        if (awaddr == `SRF_ADDR_SYS)
        begin
          next_mains_sel = wdata[0];
        end
        if (awaddr == `SRF_ADDR_IRQ_MASK)
        begin
          next_imask = wdata[3:0];
        end
        if (awaddr == `SRF_ADDR_IRQ_STAT)
        begin
          next_istat = istat & ~wdata[3:0];
        end
        if (awaddr[7:6] == 2'h0)
        begin
          unique case (o)
            `SRF_OFF_CTRL:
            begin
              next_mode[l] = srf_pkg::srf_mode_e'(wdata[1:0]);
              next_on[l] = wdata[`SRF_CTRL_ON_BIT];
            end
            `SRF_OFF_TARGET: next_target[l] = wdata[15:0];
            `SRF_OFF_RATE:   next_rate[l] = wdata[15:0];
            `SRF_OFF_TAPS:
            begin
              if (wdata[4:0] >= `SRF_TAPS_MIN && wdata[4:0] <= `SRF_TAPS_MAX && wdata[31:5] == 27'h0)
              begin
                next_taps[l] = wdata[4:0];
              end
            end
            default: ;
          endcase
        end
      end
    end
    for (int i = 0; i < 2; i++)
    begin
      next_tsel[i] = (next_mode[i] == srf_pkg::mode_table) || (next_mode[i] == srf_pkg::ramp_then_table_mode);
      // units per minute scaled to one update
      step = 16'(rate[i] / `SRF_UPD_PER_MIN);
      if (step == 16'h0000)
      begin
        step = 16'h0001;
      end
      unique case (st[i])
        srf_pkg::st_off:
        begin
          if (next_on[i])
          begin
            next_wsp[i] = next_target[i];
            next_st[i] = srf_pkg::st_reg;
          end
        end
        srf_pkg::st_reg:
        begin
          if (!next_on[i])
          begin
            next_st[i] = srf_pkg::st_off;
          end
          // new target starts a ramp; mode change alone leaves wsp
          else if (next_target[i] != target[i] && next_target[i] != wsp[i] && is_ramp(next_mode[i]))
          begin
            next_st[i] = srf_pkg::st_ramp;
            next_istat[i] = 1'b1;
          end
          else if (!is_ramp(next_mode[i]))
          begin
            next_wsp[i] = next_target[i];
          end
        end
        srf_pkg::st_ramp:
        begin
          d = (target[i] > wsp[i]) ? target[i] - wsp[i] : wsp[i] - target[i];
          if (!next_on[i])
          begin
            next_st[i] = srf_pkg::st_off;
          end
          else if (!is_ramp(next_mode[i]))
          begin
            next_wsp[i] = next_target[i];
            next_st[i] = srf_pkg::st_reg;
          end
          else if (upd_tick)
          begin
            if (d <= step)
            begin
              next_wsp[i] = target[i];
              next_st[i] = srf_pkg::st_reg;
              next_istat[i + 2] = 1'b1;
            end
            else
            begin
              next_wsp[i] = (target[i] > wsp[i]) ? wsp[i] + step : wsp[i] - step;
            end
          end
        end
      endcase
      // bin advances once per mains cycle
      if (mains_tick)
      begin
        next_bin[i] = (bin[i] + 5'h01 >= taps[i]) ? 5'h00 : bin[i] + 5'h01;
      end
      if (sample_in_valid[i])
      begin
        e = est[i][bin[i]];
        diff = $signed({sample_in[i][15], sample_in[i]}) - $signed({base[i][15], base[i]});
        resid = 18'(diff) - 18'(e);
        next_est[i][bin[i]] = e + 16'(resid >>> 3);
        next_base[i] = base[i] + 16'(diff >>> 6);
        next_soutv[i] = 1'b1;
        next_sout[i] = (taps[i] == `SRF_TAPS_MIN) ? sample_in[i] : sample_in[i] - e;
      end
    end
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rresp = mapped(araddr) ? `SRF_RESP_OKAY : `SRF_RESP_SLVERR;
      next_rdata = 32'h0000_0000;
      if (araddr == `SRF_ADDR_SYS)
        next_rdata = 32'(mains_sel);
      else if (araddr == `SRF_ADDR_IRQ_STAT)
        next_rdata = 32'(istat);
      else if (araddr == `SRF_ADDR_IRQ_MASK)
        next_rdata = 32'(imask);
      else if (araddr[7:6] == 2'h0)
      begin
        unique case (araddr[4:0])
          `SRF_OFF_CTRL:   next_rdata = 32'({on[araddr[5]], 2'h0, mode[araddr[5]]});
          `SRF_OFF_TARGET: next_rdata = 32'(target[araddr[5]]);
          `SRF_OFF_RATE:   next_rdata = 32'(rate[araddr[5]]);
          `SRF_OFF_WSP:    next_rdata = 32'(wsp[araddr[5]]);
          `SRF_OFF_STAT:   next_rdata = 32'({on[araddr[5]], tsel[araddr[5]], st[araddr[5]][2]});
          `SRF_OFF_TAPS:   next_rdata = 32'(taps[araddr[5]]);
          default:         next_rdata = 32'h0000_0000;
        endcase
      end
    end
    next_irq = |(next_istat & next_imask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode <= '{srf_pkg::mode_pid, srf_pkg::mode_pid};
      st <= '{srf_pkg::st_off, srf_pkg::st_off};
      on <= 2'h0;
      tsel <= 2'h0;
      target <= '{16'h0000, 16'h0000};
      rate <= '{16'h0000, 16'h0000};
      wsp <= '{16'h0000, 16'h0000};
      base <= '{16'h0000, 16'h0000};
      est <= '{default: 16'sh0000};
      taps <= '{`SRF_TAPS_RESET, `SRF_TAPS_RESET};
      bin <= '{5'h00, 5'h00};
      sample_out <= '0;
      sample_out_valid <= 2'h0;
      mains_sel <= 1'b0;
      istat <= 4'h0;
      imask <= 4'h0;
      irq <= 1'b0;
      upd_cnt <= 24'h00_0000;
      mains_cnt <= 24'h00_0000;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
      bresp <= 2'h0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      mode <= next_mode;
      st <= next_st;
      on <= next_on;
      tsel <= next_tsel;
      target <= next_target;
      rate <= next_rate;
      wsp <= next_wsp;
      base <= next_base;
      est <= next_est;
      taps <= next_taps;
      bin <= next_bin;
      sample_out <= next_sout;
      sample_out_valid <= next_soutv;
      mains_sel <= next_mains_sel;
      istat <= next_istat;
      imask <= next_imask;
      irq <= next_irq;
      upd_cnt <= next_upd_cnt;
      mains_cnt <= next_mains_cnt;
      awready <= next_awready;
      wready <= next_awready;
      arready <= next_arready;
      bvalid <= next_bvalid;
      rvalid <= next_rvalid;
      bresp <= next_bresp;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end
  assign pid_setpoint[0] = wsp[0];
  assign pid_setpoint[1] = wsp[1];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ramp_start_a: assert property (ce && st[0] == srf_pkg::st_reg && on[0] && is_ramp(next_mode[0]) && next_on[0]
    && next_target[0] != target[0] && next_target[0] != wsp[0] |=> ramp_active_flag[0])
    else $error("ramp did not start");
  ramp_end_a: assert property ($fell(ramp_active_flag[0]) && on[0] && is_ramp(mode[0])
    |-> pid_setpoint[0] == target[0])
    else $error("ramp ended away from target");
  step_bound_a: assert property (ce && ramp_active_flag[0] && !upd_tick |=> $stable(pid_setpoint[0]))
    else $error("setpoint moved between updates");
  ctrl_on_a: assert property (ce && st[0] == srf_pkg::st_off && next_on[0]
    |=> pid_setpoint[0] == $past(next_target[0]) && !ramp_active_flag[0])
    else $error("control start not at setpoint");
  taps_range_a: assert property (taps[0] >= `SRF_TAPS_MIN && taps[0] <= `SRF_TAPS_MAX)
    else $error("tap count out of range");
  bypass_a: assert property (ce && sample_in_valid[0] && taps[0] == `SRF_TAPS_MIN
    |=> sample_out_valid[0] && sample_out[0] == $past(sample_in[0]))
    else $error("one tap not bypassed");
  loop_indep_a: assert property (ce && wr_fire && awaddr[5] |=> $stable(rate[0]) && $stable(target[0]))
    else $error("loop one write changed loop zero");
  no_glitch_a: assert property (ce && st[0] == srf_pkg::st_reg && on[0] && next_on[0] && next_target[0] == target[0]
    && is_ramp(next_mode[0]) |=> $stable(pid_setpoint[0]))
    else $error("setpoint step on mode change");
  flag_out_a: assert property (ramp_active_flag[0] |-> on[0] && wsp[0] != target[0])
    else $error("flag without ramp");
  irq_level_a: assert property (irq == |(istat & imask))
    else $error("interrupt level mismatch");
  mains_cnt_a: assert property (mains_cnt <= 24'(MAINS_LO_CYCLES - 1))
    else $error("mains counter overrun");
  cover_ramp_c: cover property ($rose(ramp_active_flag[0]) ##[1:1000] $fell(ramp_active_flag[0]));
  cover_filter_c: cover property (sample_out_valid[1] && taps[1] == `SRF_TAPS_RESET);
  cover_irq_c: cover property ($rose(irq));
endmodule

//--- srf_defines.svh
`ifndef SRF_DEFINES_SVH
`define SRF_DEFINES_SVH
`define SRF_OFF_CTRL      5'h00
`define SRF_OFF_TARGET    5'h04
`define SRF_OFF_RATE      5'h08
`define SRF_OFF_WSP       5'h0C
`define SRF_OFF_STAT      5'h10
`define SRF_OFF_TAPS      5'h14
`define SRF_ADDR_SYS      8'h40
`define SRF_ADDR_IRQ_STAT 8'h44
`define SRF_ADDR_IRQ_MASK 8'h48
`define SRF_CTRL_ON_BIT   4
`define SRF_TAPS_RESET    5'h07
`define SRF_TAPS_MIN      5'h01
`define SRF_TAPS_MAX      5'h19
`define SRF_CLK_HZ        100000000
`define SRF_MAINS_HI_HZ   60
`define SRF_MAINS_LO_HZ   50
`define SRF_UPDATE_MS     100
`define SRF_UPD_PER_MIN   (60000 / `SRF_UPDATE_MS)
`define SRF_RESP_OKAY     2'h0
`define SRF_RESP_SLVERR   2'h2
`endif

//--- srf_pkg.sv
package srf_pkg;
  typedef enum logic [1:0] {
    mode_pid             = 2'h0,
    mode_table           = 2'h1,
    ramp_then_pid_mode   = 2'h2,
    ramp_then_table_mode = 2'h3
  } srf_mode_e;
  typedef enum logic [2:0] {
    st_off  = 3'h1,
    st_reg  = 3'h2,
    st_ramp = 3'h4
  } srf_state_e;
endpackage

//--- srf_sensor_model.sv
`timescale 1ns/1ps
module srf_sensor_model (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  output logic      [1:0][15:0] sample,
  output logic      [1:0]       valid
);
  logic [1:0]  phase;
  logic [15:0] level;
  // One sample every fourth cycle; between samples the data lines toggle so stale values never look valid
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase  <= 2'h0;
      level  <= 16'h0100;
      valid  <= 2'h0;
      sample <= '0;
    end
    else
    begin
      phase <= phase + 2'h1;
      if (phase == 2'h3)
      begin
        level     <= level + 16'h0013;
        valid     <= 2'h3;
        sample[0] <= level;
        sample[1] <= level ^ 16'h00F0;
      end
      else
      begin
        valid  <= 2'h0;
        sample <= ~sample;
      end
    end
  end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`include "srf_defines.svh"
module tb_top;
  logic             aclk;
  logic             aresetn;
  logic [7:0]       awaddr;
  logic             awvalid;
  logic             awready;
  logic [31:0]      wdata;
  logic [3:0]       wstrb;
  logic             wvalid;
  logic             wready;
  logic [1:0]       bresp;
  logic             bvalid;
  logic             bready;
  logic [7:0]       araddr;
  logic             arvalid;
  logic             arready;
  logic [31:0]      rdata;
  logic [1:0]       rresp;
  logic             rvalid;
  logic             rready;
  logic [1:0][15:0] sample_in;
  logic [1:0]       sample_in_valid;
  logic [1:0][15:0] sample_out;
  logic [1:0]       sample_out_valid;
  logic [1:0][15:0] pid_setpoint;
  logic [1:0]       ramp_active_flag;
  logic [1:0]       gain_table_select;
  logic             irq;
  logic [15:0]      last_in;
  int               fail_count = 0;
  int               checked = 0;
  int               cycles = 0;
  logic [1:0]       resp;
  logic [31:0]      data;

  srf_ramp_filter #(.MAINS_HI_CYCLES(40), .MAINS_LO_CYCLES(50), .UPDATE_CYCLES(100)) srf_ramp_filter_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sample_in(sample_in), .sample_in_valid(sample_in_valid), .sample_out(sample_out),
    .sample_out_valid(sample_out_valid), .pid_setpoint(pid_setpoint), .ramp_active_flag(ramp_active_flag),
    .gain_table_select(gain_table_select), .irq(irq));
  srf_sensor_model srf_sensor_model_inst (.aclk(aclk), .aresetn(aresetn), .sample(sample_in),
    .valid(sample_in_valid));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    if (sample_in_valid[0] === 1'b1)
      last_in <= sample_in[0];
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fail_count = fail_count + 1;
      conclude();
    end
  end

  task automatic conclude();
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked = checked + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wreg(input int n, input logic [7:0] off, input logic [31:0] d);
    axi_wr(8'(n * 32) + off, d, resp);
  endtask

  task automatic wait_ramp(input int n, input logic [15:0] start, input logic [15:0] tgt, input logic [15:0] step);
    logic [15:0] prev;
    logic [15:0] exp;
    int          i;
    prev = start;
    for (i = 0; i < 5000 && pid_setpoint[n] !== tgt; i++)
    begin
      @(posedge aclk);
      if (pid_setpoint[n] !== prev)
      begin
        if (tgt > prev)
          exp = (tgt - prev <= step) ? tgt : prev + step;
        else
          exp = (prev - tgt <= step) ? tgt : prev - step;
        chk("wsp step", 32'(exp), 32'(pid_setpoint[n]));
        chk("flag while ramping", 32'h1, 32'(ramp_active_flag[n] | (pid_setpoint[n] == tgt)));
        prev = pid_setpoint[n];
      end
    end
    chk("wsp final", 32'(tgt), 32'(pid_setpoint[n]));
    chk("flag cleared", 32'h0, 32'(ramp_active_flag[n]));
  endtask

  task automatic test_reset_map();
    axi_rd(8'(`SRF_OFF_TAPS), data, resp);
    chk("taps reset", 32'h0000_0007, data);
    axi_rd(8'h60, data, resp);
    chk("unmapped resp", 32'(`SRF_RESP_SLVERR), 32'(resp));
    chk("unmapped data", 32'h0000_0000, data);
    axi_wr(8'h60, 32'h0000_0001, resp);
    chk("unmapped wresp", 32'(`SRF_RESP_SLVERR), 32'(resp));
    axi_wr(`SRF_ADDR_SYS, 32'h0000_0001, resp);
    axi_rd(`SRF_ADDR_SYS, data, resp);
    chk("mains select", 32'h0000_0001, data);
  endtask

  task automatic test_taps();
    wreg(0, 8'(`SRF_OFF_TAPS), 32'h0000_001A);
    axi_rd(8'(`SRF_OFF_TAPS), data, resp);
    chk("taps 26 ignored", 32'h0000_0007, data);
    wreg(0, 8'(`SRF_OFF_TAPS), 32'h0000_0019);
    axi_rd(8'(`SRF_OFF_TAPS), data, resp);
    chk("taps 25 taken", 32'h0000_0019, data);
    wreg(0, 8'(`SRF_OFF_TAPS), 32'h0000_0001);
    repeat (3)
    begin
      do @(posedge aclk); while (sample_out_valid[0] !== 1'b1);
      chk("bypass sample", 32'(last_in), 32'(sample_out[0]));
    end
  endtask

  task automatic test_ramp_pid();
    wreg(0, 8'(`SRF_OFF_RATE), 32'h0000_1770);
    wreg(0, 8'(`SRF_OFF_TARGET), 32'h0000_0064);
    wreg(0, 8'(`SRF_OFF_CTRL), 32'h0000_0012);
    repeat (2) @(posedge aclk);
    chk("on at setpoint", 32'h0000_0064, 32'(pid_setpoint[0]));
    chk("no ramp at on", 32'h0, 32'(ramp_active_flag[0]));
    wreg(0, 8'(`SRF_OFF_TARGET), 32'h0000_0096);
    chk("ramp started", 32'h1, 32'(ramp_active_flag[0]));
    axi_rd(8'(`SRF_OFF_STAT), data, resp);
    chk("stat readable", 32'h0000_0005, data);
    chk("pid gains", 32'h0, 32'(gain_table_select[0]));
    wait_ramp(0, 16'h0064, 16'h0096, 16'h000A);
    chk("irq masked", 32'h0, 32'(irq));
    wreg(0, 8'(`SRF_OFF_TARGET), 32'h0000_0082);
    chk("fresh ramp", 32'h1, 32'(ramp_active_flag[0]));
    wait_ramp(0, 16'h0096, 16'h0082, 16'h000A);
  endtask

  task automatic test_irq();
    axi_wr(`SRF_ADDR_IRQ_MASK, 32'h0000_000F, resp);
    repeat (2) @(posedge aclk);
    chk("irq raised", 32'h1, 32'(irq));
    axi_rd(`SRF_ADDR_IRQ_STAT, data, resp);
    chk("irq status", 32'h0000_0005, data);
    axi_wr(`SRF_ADDR_IRQ_STAT, 32'h0000_0005, resp);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, 32'(irq));
  endtask

  task automatic test_loop1_table();
    wreg(1, 8'(`SRF_OFF_RATE), 32'h0000_0064);
    wreg(1, 8'(`SRF_OFF_TARGET), 32'h0000_00C8);
    wreg(1, 8'(`SRF_OFF_CTRL), 32'h0000_0010);
    wreg(1, 8'(`SRF_OFF_CTRL), 32'h0000_0013);
    repeat (2) @(posedge aclk);
    chk("mode change no step", 32'h0000_00C8, 32'(pid_setpoint[1]));
    chk("mode change no ramp", 32'h0, 32'(ramp_active_flag[1]));
    wreg(1, 8'(`SRF_OFF_TARGET), 32'h0000_00B4);
    chk("loop1 ramping", 32'h1, 32'(ramp_active_flag[1]));
    chk("table gains", 32'h1, 32'(gain_table_select[1]));
    chk("loop0 untouched", 32'h0000_0082, 32'(pid_setpoint[0]));
    wait_ramp(1, 16'h00C8, 16'h00B4, 16'h0001);
    chk("table after ramp", 32'h1, 32'(gain_table_select[1]));
  endtask

  initial
  begin
    aresetn <= 1'b0;
    awaddr  <= 8'h00;
    awvalid <= 1'b0;
    wdata   <= 32'h0000_0000;
    wstrb   <= 4'h0;
    wvalid  <= 1'b0;
    bready  <= 1'b0;
    araddr  <= 8'h00;
    arvalid <= 1'b0;
    rready  <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset_map();
    test_taps();
    test_ramp_pid();
    test_irq();
    test_loop1_table();
    conclude();
  end
endmodule
